// ### src/ebrg_arbiter.sv
// bus request and grant arbiter sitting in front of the processor core
// assumes the core reports its external accesses on clk_i and obeys halt
`timescale 1ns/10ps
`default_nettype none
`include "ebrg_cfg.svh"
// Function
// - idle bus: grant, float, halt next cycle
// - continue mode: halt only at external access
// - access in progress: grant after it ends
// - grant mid-instruction, wait only access end
// - grant in gap between two accesses
// - request withdrawn: ungrant, drive, resume
// - requests served during reset and boot
// - hung output when stalled needing bus
// - on return drop grant, hung; access proceeds
// - emulator enable selects emulator pins
// - emulator mode floats normal grant output
module ebrg_arbiter
(
   input wire logic clk_i, // processor instruction clock
   input wire logic arst_n_i, // power-on reset, active low
   input wire logic bus_request_n_i, // system bus request pin
   input wire logic reset_n_i, // system reset pin
   input wire logic emulator_enable_i, // emulator takes control
   input wire logic emulator_reset_n_i, // emulator reset pin
   input wire logic emulator_bus_request_n_i, // emulator bus request pin
   input wire logic go_mode_i, // continue until external access
   input wire logic ext_access_busy_i, // core external access this cycle
   input wire logic ext_access_need_i, // core wants bus for mem or dma
   output logic bus_grant_n_o, // normal grant pin level
   output logic bus_grant_oe_o, // normal grant driver enable
   output logic emulator_bus_grant_n_o, // emulator grant pin
   output logic grant_hung_n_o, // stalled needing the bus
   output logic bus_drive_en_o, // enable for data, addr, strobes
   output logic core_halt_o, // stop the core
   output logic core_reset_n_o // selected reset to the core
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   // every pin below is asynchronous to clk_i, so each passes two
   // flip-flops before the arbiter reads it; this costs two cycles of
   // request latency, which the master simply sees as a slower grant
   logic sys_req_n_sync; // system request, active low
   logic emu_req_n_sync; // emulator request, active low
   logic rst_sync; // system reset, active low
   logic erst_sync; // emulator reset, active low
   logic emu_on_sync; // emulator control, active high
   logic emu_off_sync; // emulator control as synchronised, inverted
   logic [4:0] pin_raw; // raw pin levels, one per synchroniser
   logic [4:0] pin_sync; // the same levels after two flops
   // enable is active high; inverted through the sync so reset reads low
   assign pin_raw = {~emulator_enable_i, emulator_reset_n_i, reset_n_i,
      emulator_bus_request_n_i, bus_request_n_i};
   // one synchroniser per pin, all alike
   genvar pin_idx;
   generate
      for (pin_idx = 0; pin_idx < 5; pin_idx = pin_idx + 1)
      begin : g_pin_sync
         ebrg_sync u_sync
         (
            .clk_i(clk_i),
            .arst_n_i(arst_n_i),
            .d_i(pin_raw[pin_idx]),
            .q_o(pin_sync[pin_idx])
         );
      end
   endgenerate
   // split the vector back into named levels
   assign sys_req_n_sync = pin_sync[0];
   assign emu_req_n_sync = pin_sync[1];
   assign rst_sync = pin_sync[2];
   assign erst_sync = pin_sync[3];
   assign emu_off_sync = pin_sync[4];
   assign emu_on_sync = ~emu_off_sync;
   // ----------------------------------------
   // pin selection
   // ----------------------------------------
   logic req;
   // emulator pins replace the system pins when enabled
   assign req = emu_on_sync ? ~emu_req_n_sync : ~sys_req_n_sync;
   assign core_reset_n_o = emu_on_sync ? erst_sync : rst_sync;
   // ----------------------------------------
   // arbiter state
   // ----------------------------------------
   ebrg_pkg::ebrg_state_e state_q;
   ebrg_pkg::ebrg_state_e state_d;
   // next state; reset pin is not an input here so requests work in reset
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ebrg_pkg::ST_OWN:
         begin
            // wait only for the current access, not the instruction
            // the gap between two accesses is a non-busy cycle
            if (req && !ext_access_busy_i)
               state_d = ebrg_pkg::ST_GRANTED;
         end
         ebrg_pkg::ST_GRANTED:
         begin
            if (!req)
               state_d = ebrg_pkg::ST_OWN;
            else if (ext_access_need_i)
               state_d = ebrg_pkg::ST_HUNG;
         end
         ebrg_pkg::ST_HUNG:
         begin
            // master answers the hung flag by dropping its request
            if (!req)
               state_d = ebrg_pkg::ST_OWN;
         end
         default:
            state_d = ebrg_pkg::ST_OWN;
      endcase
   end
   // state register
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         state_q <= ebrg_pkg::ST_OWN;
      else
         state_q <= state_d;
   end
   // ----------------------------------------
   // registered pin outputs
   // ----------------------------------------
   logic grant_n_q;
   logic hung_n_q;
   logic granted;
   assign granted = (state_q != ebrg_pkg::ST_OWN);
   // grant and hung follow state; both drop together on return
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         grant_n_q <= `EBRG_GRANT_RST;
         hung_n_q <= `EBRG_HUNG_RST;
      end
      else
      begin
         grant_n_q <= (state_d == ebrg_pkg::ST_OWN);
         hung_n_q <= (state_d != ebrg_pkg::ST_HUNG);
      end
   end
   assign bus_grant_n_o = grant_n_q;
   assign emulator_bus_grant_n_o = emu_on_sync ? grant_n_q : 1'b1;
   // normal grant floats under emulator control
   assign bus_grant_oe_o = ~emu_on_sync;
   // shared lines float whenever granted; master owns them then
   assign bus_drive_en_o = grant_n_q;
   // halt: at once normally, at the first external need in go mode
   // going back to own resumes the core where it stopped
   // a hung core stays halted even if its need flickers
   assign core_halt_o = granted
      && (!go_mode_i || ext_access_need_i || state_q == ebrg_pkg::ST_HUNG);
   // ----------------------------------------
   // checks
   // ----------------------------------------
   // every check runs on the processor clock and is off while the
   // power-on reset is low; the system reset pin does not disable them,
   // since requests must still be served while the core sits in reset
   // an idle bus is handed over one cycle after the request is seen
   chk_grant_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (state_q == ebrg_pkg::ST_OWN && req && !ext_access_busy_i) |=> !bus_grant_n_o)
      else $error("grant not given on idle bus");

   // a running external access keeps the bus with the processor
   chk_wait_access: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (state_q == ebrg_pkg::ST_OWN && ext_access_busy_i) |=> bus_grant_n_o)
      else $error("grant given during external access");

   // shared lines follow the grant flop alone, which tracks the state
   chk_float_granted: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (state_q != ebrg_pkg::ST_OWN) |-> !bus_drive_en_o)
      else $error("bus driven while granted");

   // go mode keeps the core running until it needs the bus
   chk_go_mode: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (state_q == ebrg_pkg::ST_GRANTED && go_mode_i && !ext_access_need_i) |-> !core_halt_o)
      else $error("go mode halted without need");

   // dropping the request gives everything back in one cycle
   chk_release: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (granted && !req) |=> (bus_grant_n_o && bus_drive_en_o && !core_halt_o))
      else $error("release not honoured");

   // a need while granted raises the hung flag next cycle
   chk_hung_set: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (state_q == ebrg_pkg::ST_GRANTED && req && ext_access_need_i) |=> !grant_hung_n_o)
      else $error("hung flag missing");

   // grant and hung go away together on return
   chk_hung_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (!grant_hung_n_o && !req) |=> (grant_hung_n_o && bus_grant_n_o))
      else $error("hung not cleared on return");

   // hung only makes sense while the bus is away
   chk_hung_only: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !grant_hung_n_o |-> !bus_grant_n_o)
      else $error("hung without grant");

   // normal grant pin is released under emulator control
   chk_emu_float: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      emu_on_sync |-> !bus_grant_oe_o)
      else $error("grant driven in emulator mode");

   // a held core reset does not block the arbiter
   chk_reset_serve: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (!core_reset_n_o && state_q == ebrg_pkg::ST_OWN && req && !ext_access_busy_i)
      |=> !bus_grant_n_o)
      else $error("request ignored in reset");

   // grant stands for as long as the request is held
   chk_grant_stands: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (granted && req) |=> !bus_grant_n_o)
      else $error("grant dropped while requested");

   // no request, no grant
   chk_no_request: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (state_q == ebrg_pkg::ST_OWN && !req) |=> bus_grant_n_o)
      else $error("grant without request");

   // outside go mode the core stops as soon as the bus is away
   chk_halt_plain: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (granted && !go_mode_i) |-> core_halt_o)
      else $error("core not halted while granted");

   // in go mode an external need stops the core
   chk_halt_need: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (granted && ext_access_need_i) |-> core_halt_o)
      else $error("core not halted on need");

   // owning the bus means the core runs
   chk_run_own: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (state_q == ebrg_pkg::ST_OWN) |-> !core_halt_o)
      else $error("core halted while owning bus");

   // hung stands while the master keeps the bus
   chk_hung_stands: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (state_q == ebrg_pkg::ST_HUNG && req) |=> !grant_hung_n_o)
      else $error("hung dropped while requested");

   // hung never jumps straight from owning the bus
   chk_hung_entry: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (state_q == ebrg_pkg::ST_OWN) |=> grant_hung_n_o)
      else $error("hung raised from own");

   // processor drives the shared lines whenever it owns them
   chk_drive_own: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (state_q == ebrg_pkg::ST_OWN) |-> bus_drive_en_o)
      else $error("bus not driven while owned");

   // a free cycle between two accesses is used for the grant
   chk_access_gap: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (state_q == ebrg_pkg::ST_OWN && req && $past(ext_access_busy_i) && !ext_access_busy_i)
      |=> !bus_grant_n_o)
      else $error("gap between accesses not used");

   // emulator grant pin idles high outside emulator control
   chk_emu_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !emu_on_sync |-> emulator_bus_grant_n_o)
      else $error("emulator grant outside emulator mode");

   // emulator grant carries the arbiter grant in emulator mode
   chk_emu_follow: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      emu_on_sync |-> (emulator_bus_grant_n_o == bus_grant_n_o))
      else $error("emulator grant differs from grant");

   // normal grant pin is driven outside emulator control
   chk_sys_drive: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !emu_on_sync |-> bus_grant_oe_o)
      else $error("grant pin floated in normal mode");

   // shared lines stay released in reset while granted
   chk_reset_float: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (!core_reset_n_o && state_q != ebrg_pkg::ST_OWN) |-> !bus_drive_en_o)
      else $error("bus driven in reset while granted");

   // a hung core never runs
   chk_hung_halt: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (state_q == ebrg_pkg::ST_HUNG) |-> core_halt_o)
      else $error("core runs while hung");

   // emulator request alone wins the bus in emulator mode
   chk_emu_request: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (emu_on_sync && state_q == ebrg_pkg::ST_OWN && !ext_access_busy_i && !emu_req_n_sync)
      |=> !bus_grant_n_o)
      else $error("emulator request ignored");

   // without an emulator request the bus stays home in emulator mode
   chk_emu_quiet: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (emu_on_sync && state_q == ebrg_pkg::ST_OWN && emu_req_n_sync)
      |=> bus_grant_n_o)
      else $error("grant without emulator request");

   // ----------------------------------------
   // scenario covers
   // ----------------------------------------
   // plain grant
   cov_grant: cover property (@(posedge clk_i) disable iff (!arst_n_i)
      bus_grant_n_o ##1 !bus_grant_n_o);
   // hung raised and later cleared
   cov_hung: cover property (@(posedge clk_i) disable iff (!arst_n_i)
      grant_hung_n_o ##1 !grant_hung_n_o ##1 grant_hung_n_o);
   // grant held back by an access
   cov_delayed: cover property (@(posedge clk_i) disable iff (!arst_n_i)
      (req && ext_access_busy_i && state_q == ebrg_pkg::ST_OWN) ##1 !ext_access_busy_i);
   // grant on the emulator pin
   cov_emu: cover property (@(posedge clk_i) disable iff (!arst_n_i)
      emu_on_sync && !emulator_bus_grant_n_o);
   // core still running while granted in go mode
   cov_go_run: cover property (@(posedge clk_i) disable iff (!arst_n_i)
      granted && go_mode_i && !core_halt_o);
   // hung output from its own flop
   assign grant_hung_n_o = hung_n_q;
endmodule : ebrg_arbiter
`default_nettype wire

// ### src/ebrg_cfg.svh
// constants for the external bus request and grant block
// assumes inclusion by bare name from the design files
`ifndef EBRG_CFG_SVH
`define EBRG_CFG_SVH
// reset values of the active-low pin drivers (released)
`define EBRG_GRANT_RST 1'b1
`define EBRG_HUNG_RST 1'b1
// synchroniser flops reset to the released (high) level
`define EBRG_SYNC_RST 1'b1
// synchroniser depth for pin inputs
`define EBRG_SYNC_DEPTH 2
`endif

// ### src/ebrg_pkg.sv
// types shared by the bus request and grant block
// assumes the cfg header is included by each design file
package ebrg_pkg;
   // ----------------------------------------
   // arbiter states, one-hot
   // ----------------------------------------
   typedef enum logic [2:0]
   {
      ST_OWN = 3'b001, // processor owns the bus
      ST_GRANTED = 3'b010, // bus handed to the external master
      ST_HUNG = 3'b100 // granted and processor stalled on the bus
   } ebrg_state_e;
endpackage : ebrg_pkg

// ### src/ebrg_sync.sv
// two flip-flop synchroniser for the request, reset and enable pins
// assumes pins are asynchronous to clk_i
`timescale 1ns/10ps
`default_nettype none
`include "ebrg_cfg.svh"
module ebrg_sync
(
   input wire logic clk_i, // processor clock
   input wire logic arst_n_i, // async reset, active low
   input wire logic d_i, // raw pin level
   output logic q_o // synchronised level
);
   // ----------------------------------------
   // first stage is read only by the second stage
   // ----------------------------------------
   logic meta_q;
   logic sync_q;
   // reset to released (high) so a held pin only acts after two edges
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         meta_q <= `EBRG_SYNC_RST;
         sync_q <= `EBRG_SYNC_RST;
      end
      else
      begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end
   assign q_o = sync_q;
endmodule : ebrg_sync
`default_nettype wire

// ### tb/ebrg_master_model.sv
// external bus master model that borrows the bus through request and grant
// assumes grant and hung arrive as active-low levels on clk_i
`timescale 1ns/10ps
`default_nettype none
module ebrg_master_model #(parameter int HOLD = 6)
(
   input wire logic clk_i, // processor clock
   input wire logic arst_n_i, // async reset, active low
   input wire logic want_i, // bench asks for the bus
   input wire logic bus_grant_n_i, // grant seen at the pin
   input wire logic grant_hung_n_i, // device stalled on the bus
   output logic bus_request_n_o, // request pin, active low
   output logic drive_o // master drives shared lines
);
   int cnt; // cycles spent owning the bus
   // request, own, release; never reuse a stale grant
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         bus_request_n_o <= 1'b1;
         drive_o <= 1'b0;
         cnt <= 0;
      end
      else if (drive_o)
      begin
         if (cnt >= HOLD || !grant_hung_n_i) drive_o <= 1'b0;
         cnt <= cnt + 1;
      end
      else if (!bus_request_n_o && !bus_grant_n_i && cnt == 0) drive_o <= 1'b1;
      else if (!bus_request_n_o && cnt != 0)
      begin
         bus_request_n_o <= 1'b1;
         cnt <= 0;
      end
      else if (want_i && bus_grant_n_i) bus_request_n_o <= 1'b0;
   end
endmodule : ebrg_master_model
`default_nettype wire

// ### tb/external_bus_request_grant_tb.sv
// self-checking bench: cycle model of the arbiter compared every cycle
// assumes two master models, one on system pins and one on emulator pins
`timescale 1ns/10ps
`default_nettype none
module external_bus_request_grant_tb;
   logic clk_i = 1'b0, arst_n_i = 1'b0, reset_n_i = 1'b1, emulator_enable_i = 1'b0;
   logic emulator_reset_n_i = 1'b1, go_mode_i = 1'b0, ext_access_busy_i = 1'b0;
   logic ext_access_need_i = 1'b0, want = 1'b0, emu_want = 1'b0;
   logic req_n, emu_req_n, drv_sys, drv_emu, bus_grant_n_o, bus_grant_oe_o;
   logic emulator_bus_grant_n_o, grant_hung_n_o, bus_drive_en_o, core_halt_o, core_reset_n_o;
   wire logic grant_pin = bus_grant_oe_o ? bus_grant_n_o : 1'b1; // pulled up when floated
   int num_errors = 0, samples_checked = 0, seed = 44415, r;
   bit rq1, rq2, eq1, eq2, em1, em2, rs1, rs2, es1, es2; // model pin sync stages
   int st, sel; // model state and selected request
   int emu_t[5] = '{0, 0, 1, 0, 1}, go_t[5] = '{0, 0, 1, 0, 1}, rst_t[5] = '{0, 0, 0, 1, 0};
   always #12.5 clk_i = ~clk_i;
   ebrg_arbiter ebrg_arbiter_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .bus_request_n_i(req_n), .reset_n_i(reset_n_i), .emulator_enable_i(emulator_enable_i),
      .emulator_reset_n_i(emulator_reset_n_i), .emulator_bus_request_n_i(emu_req_n),
      .go_mode_i(go_mode_i), .ext_access_busy_i(ext_access_busy_i),
      .ext_access_need_i(ext_access_need_i), .bus_grant_n_o(bus_grant_n_o),
      .bus_grant_oe_o(bus_grant_oe_o), .emulator_bus_grant_n_o(emulator_bus_grant_n_o),
      .grant_hung_n_o(grant_hung_n_o), .bus_drive_en_o(bus_drive_en_o),
      .core_halt_o(core_halt_o), .core_reset_n_o(core_reset_n_o));
   ebrg_master_model ebrg_master_model_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .want_i(want), .bus_grant_n_i(grant_pin), .grant_hung_n_i(grant_hung_n_o),
      .bus_request_n_o(req_n), .drive_o(drv_sys));
   ebrg_master_model emu_master_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .want_i(emu_want), .bus_grant_n_i(emulator_bus_grant_n_o),
      .grant_hung_n_i(grant_hung_n_o), .bus_request_n_o(emu_req_n), .drive_o(drv_emu));
   function automatic int xorshift(input int x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift
   task automatic chk(input string name, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected %s: expected %b seen %b", name, exp, got);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checked %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : tally_and_finish
   // model: two-flop pin sync, state 0 own, 1 granted, 2 hung
   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         {rq1, rq2, eq1, eq2, em1, em2, rs1, rs2, es1, es2} = 10'h00F;
         st = 0;
      end
      else
      begin
         sel = em2 ? eq2 : rq2;
         if (st == 0) st = (sel && !ext_access_busy_i) ? 1 : 0;
         else if (!sel) st = 0;
         else if (st == 1 && ext_access_need_i) st = 2;
         {rq2, eq2, em2, rs2, es2} = {rq1, eq1, em1, rs1, es1};
         {rq1, eq1, em1} = {!req_n, !emu_req_n, emulator_enable_i};
         {rs1, es1} = {reset_n_i, emulator_reset_n_i};
      end
   end
   // compare on the falling edge, where every output has settled
   always @(negedge clk_i)
   begin
      if (arst_n_i)
      begin
         chk("bus_grant_oe", !em2, bus_grant_oe_o);
         if (!em2) chk("bus_grant_n", st == 0, bus_grant_n_o);
         chk("emulator_bus_grant_n", !em2 || st == 0, emulator_bus_grant_n_o);
         chk("grant_hung_n", st != 2, grant_hung_n_o);
         chk("bus_drive_en", st == 0, bus_drive_en_o);
         chk("core_halt", st != 0 && (!go_mode_i || ext_access_need_i || st == 2),
            core_halt_o);
         chk("core_reset_n", em2 ? es2 : rs2, core_reset_n_o);
         chk("bus_contention", 1'b0, (drv_sys | drv_emu) & bus_drive_en_o);
      end
   end
   // watchdog, well beyond five phases of some 330 cycles
   initial
   begin
      repeat (4000) @(posedge clk_i);
      num_errors++;
      tally_and_finish();
   end
   // phases: plain, busy core, go mode under emulator control, reset held, emulator control in go mode
   initial
   begin
      repeat (4) @(posedge clk_i);
      arst_n_i <= 1'b1;
      for (int p = 0; p < 5; p++)
      begin
         emulator_enable_i <= emu_t[p][0];
         go_mode_i <= go_t[p][0];
         repeat (8) @(posedge clk_i);
         repeat (300)
         begin
            @(posedge clk_i);
            seed = xorshift(seed);
            r = seed;
            ext_access_busy_i <= (p != 0) && r[0] && r[1];
            ext_access_need_i <= r[2];
            if (emu_t[p] != 0) emu_want <= r[3];
            else want <= r[3];
            if (emu_t[p] != 0) {reset_n_i, emulator_reset_n_i} <= {r[4], r[5] | r[6]};
            else {emulator_reset_n_i, reset_n_i} <= {r[4], !rst_t[p][0] && (r[5] | r[6])};
         end
         // let the last random values meet one edge before going idle
         @(posedge clk_i);
         {want, emu_want, ext_access_busy_i, reset_n_i, emulator_reset_n_i} <= 5'h03;
         repeat (20) @(posedge clk_i);
         $display("test %0d done", p);
      end
      tally_and_finish();
   end
endmodule : external_bus_request_grant_tb
`default_nettype wire
